// >>> dv/tb_top.sv
// Purpose: Self-checking bench for switch host access and slot control
// Assumes: Host model drives the microport, bench drives slot ports
// Notes: Drive pin passes two sync flops, so waits of four cycles
`timescale 1ns/1ps
module tb_top;
  import tsiha_pkg::*;
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic drive_pin = 1'b0;
  logic oe;
  tsiha_slot_req_t slot_req = '0;
  tsiha_dm_wr_t dm_wr = '0;
  tsiha_pins_t pins;
  logic [7:0] dout;
  logic [7:0] slot_data;
  logic ack_b;
  logic drive;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;

  initial forever #12.5 clock_in = ~clock_in;

  tsiha_host_model host_u (.clk_in(clock_in), .ack_b_in(ack_b),
    .dout_in(dout), .oe_in(oe), .pins_out(pins));

  tsiha_top dut_u (.clk_in(clock_in), .rst_b_in(rst_b_in),
    .chip_sel_b_in(pins.cs_b), .data_strobe_in(pins.ds),
    .rw_in(pins.rw), .addr_in(pins.addr), .data_in(pins.data),
    .data_out(dout), .data_oe_out(oe), .access_ack_strobe_b_out(ack_b),
    .master_output_drive_in(drive_pin), .slot_req_in(slot_req),
    .dm_wr_in(dm_wr), .slot_data_out(slot_data),
    .slot_drive_out(drive));

  task automatic summarize();
    if (bad_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(logic [5:0] a, logic [7:0] d);
    logic [7:0] r;
    logic o;
    int n;
    host_u.access(1'b0, a, d, r, o, n);
    check("write_ack", {7'h0, n <= CM_ACK_CYC}, 8'h01);
    check("write_oe", {7'h0, o}, 8'h00);
  endtask

  task automatic rd(logic [5:0] a, logic [7:0] exp);
    logic [7:0] r;
    logic o;
    int n;
    host_u.access(1'b1, a, 8'h00, r, o, n);
    check("read_ack", {7'h0, n <= CM_ACK_CYC}, 8'h01);
    check("read_oe", {7'h0, o}, 8'h01);
    check("read_data", r, exp);
  endtask

  task automatic slot(logic [1:0] s, logic [4:0] c, logic [7:0] d,
                      logic en);
    @(posedge clock_in);
    slot_req <= '{valid: 1'b1, stream: s, chan: c};
    @(posedge clock_in);
    slot_req.valid <= 1'b0;
    @(negedge clock_in);
    check("slot_data", slot_data, d);
    check("slot_drive", {7'h0, drive}, {7'h0, en});
  endtask

  task automatic dm(logic [6:0] i, logic [7:0] d);
    @(posedge clock_in);
    dm_wr <= '{valid: 1'b1, idx: i, data: d};
    @(posedge clock_in);
    dm_wr.valid <= 1'b0;
  endtask

  task automatic set_drive_pin(logic v);
    @(posedge clock_in);
    drive_pin <= v;
    repeat (4) @(posedge clock_in);
  endtask

  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      bad_count++;
      summarize();
    end
  end

  initial begin
    repeat (8) @(posedge clock_in);
    rst_b_in <= 1'b1;
    rd(6'h00, CTRL_RESET);
    wr(6'h1c, 8'hff);
    rd(6'h00, 8'hff & CTRL_RW_MASK);
    wr(6'h00, 8'h00);
    wr(6'h03, 8'h55);
    rd(6'h01, 8'h00);
    rd(6'h00, 8'h00);
    wr(6'h25, 8'h66);
    rd(6'h25, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(6'h00, {3'h0, MEM_CONN_LOW, 1'b0, 2'(s)});
      wr(6'h20, {2'(s), 6'h0a});
      wr(6'h3f, {2'(s), 6'h15});
      wr(6'h00, {3'h0, MEM_CONN_HIGH, 1'b0, 2'(s)});
      wr(6'h20, 8'h00);
      wr(6'h3f, 8'h00);
    end
    for (int s = 0; s < 4; s++) begin
      wr(6'h00, {3'h0, MEM_CONN_LOW, 1'b0, 2'(s)});
      rd(6'h20, {2'(s), 6'h0a});
      rd(6'h3f, {2'(s), 6'h15});
      wr(6'h00, {3'h0, MEM_CONN_HIGH, 1'b0, 2'(s)});
      rd(6'h3f, 8'h00);
    end
    dm(7'h45, 8'hc3);
    dm(7'h26, 8'h9a);
    wr(6'h00, {3'h0, MEM_DATA, 1'b0, 2'h2});
    rd(6'h25, 8'hc3);
    wr(6'h25, 8'h11);
    rd(6'h25, 8'hc3);
    wr(6'h00, {3'h4, MEM_CONN_HIGH, 1'b0, 2'h2});
    wr(6'h25, 8'ha6);
    rd(6'h25, 8'hc3);
    wr(6'h00, {3'h0, MEM_CONN_LOW, 1'b0, 2'h2});
    rd(6'h25, 8'ha6);
    wr(6'h00, {3'h0, MEM_CONN_HIGH, 1'b0, 2'h2});
    wr(6'h25, 8'h01);
    // Enables are programmed before the drive pin rises
    set_drive_pin(1'b1);
    slot(2'h2, 5'h05, 8'h9a, 1'b1);
    wr(6'h25, 8'h05);
    slot(2'h2, 5'h05, 8'ha6, 1'b1);
    wr(6'h25, 8'h04);
    slot(2'h2, 5'h05, 8'ha6, 1'b0);
    wr(6'h25, 8'h00);
    wr(6'h00, 8'h40);
    slot(2'h2, 5'h05, 8'ha6, 1'b1);
    set_drive_pin(1'b0);
    // Falling pin must release the slot with no new request
    check("drive_release", {7'h0, drive}, 8'h00);
    slot(2'h2, 5'h05, 8'ha6, 1'b0);
    summarize();
  end
endmodule

// >>> dv/tsiha_host_model.sv
// Purpose: Host processor model for the switch microport
// Assumes: Bench calls access through the instance path
// Notes: Released lines show inverted values, never the last one
`timescale 1ns/1ps
module tsiha_host_model
  import tsiha_pkg::*;
(
  input wire logic clk_in,                // core clock
  input wire logic ack_b_in,              // acknowledge, low
  input wire logic [DATA_W-1:0] dout_in,  // read data from block
  input wire logic oe_in,                 // block drives data bus
  output tsiha_pins_t pins_out            // host pins toward block
);
  initial pins_out = PINS_RESET;

  // Holds every qualifier until ack is sampled, one byte per strobe
  task automatic access(input logic rd, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] r, output logic o,
                        output int n);
    int k;
    @(posedge clk_in);
    pins_out.cs_b <= 1'b0;
    pins_out.ds <= 1'b1;
    pins_out.rw <= rd;
    pins_out.addr <= a;
    pins_out.data <= rd ? ~pins_out.data : d;
    n = 0;
    while (ack_b_in !== 1'b0 && n < 100) begin
      @(posedge clk_in);
      n++;
    end
    r = dout_in;
    o = oe_in;
    pins_out.cs_b <= 1'b1;
    pins_out.ds <= 1'b0;
    pins_out.rw <= ~rd;
    pins_out.addr <= ~a;
    pins_out.data <= ~pins_out.data;
    k = 0;
    // Next strobe only once ack is released
    while (ack_b_in !== 1'b1 && k < 100) begin
      @(posedge clk_in);
      k++;
    end
  endtask
endmodule

// >>> hdl/tsiha_mem.sv
// Purpose: 128 x 8 flip-flop memory, one write port, two read ports
// Assumes: Single clock, content undefined until written
// Notes: No reset on storage, as in the switch itself
`timescale 1ns/1ps
module tsiha_mem
  import tsiha_pkg::*;
(
  input wire logic clk_in,                    // core clock
  input wire logic wr_en_in,                  // write strobe
  input wire logic [IDX_W-1:0] wr_idx_in,     // write index
  input wire logic [DATA_W-1:0] wr_data_in,   // write data
  input wire logic [IDX_W-1:0] rd_a_idx_in,   // host read index
  output logic [DATA_W-1:0] rd_a_data_out,    // host read data
  input wire logic [IDX_W-1:0] rd_b_idx_in,   // slot read index
  output logic [DATA_W-1:0] rd_b_data_out     // slot read data
);

  logic [DATA_W-1:0] mem_q [MEM_DEPTH];

  for (genvar i = 0; i < MEM_DEPTH; i++) begin : g_entry
    always_ff @(posedge clk_in) begin
      if (wr_en_in && wr_idx_in == IDX_W'(i)) begin
        mem_q[i] <= wr_data_in;
      end
    end
  end

  assign rd_a_data_out = mem_q[rd_a_idx_in];
  assign rd_b_data_out = mem_q[rd_b_idx_in];

endmodule

// >>> hdl/tsiha_pkg.sv
// Purpose: Shared constants and carriers for the switch host access block
// Assumes: 40 MHz core clock, 6-bit address, 8-bit data host port
// Notes: Memory depth is 4 streams of 32 channels
package tsiha_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int CHAN_W = 5;
  localparam int STRM_W = 2;
  localparam int IDX_W = 7;
  localparam int MEM_DEPTH = 128;

  // Address decode
  localparam int ADDR_CHAN_BIT = 5;
  localparam logic [1:0] CTRL_LOW_ADDR = 2'h0;

  // switch_control layout
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_RW_MASK = 8'hdb;
  localparam int CTRL_SPLIT_BIT = 7;
  localparam int CTRL_FORCE_BIT = 6;
  localparam int CTRL_MEM_HI = 4;
  localparam int CTRL_MEM_LO = 3;
  localparam int CTRL_STRM_HI = 1;
  localparam int CTRL_STRM_LO = 0;

  // target_memory_field codes
  localparam logic [1:0] MEM_NONE = 2'h0;
  localparam logic [1:0] MEM_DATA = 2'h1;
  localparam logic [1:0] MEM_CONN_LOW = 2'h2;
  localparam logic [1:0] MEM_CONN_HIGH = 2'h3;

  // conn_mem_high and conn_mem_low fields
  localparam int HIGH_SRC_BIT = 2;
  localparam int HIGH_OE_BIT = 0;
  localparam int LOW_ADDR_HI = 6;
  localparam int LOW_ADDR_LO = 0;

  // Acknowledge limits
  localparam int CLK_HZ = 40_000_000;
  localparam int CM_ACK_NS = 800;
  localparam int DM_ACK_NS = 1220;
  localparam int CM_ACK_CYC = (CM_ACK_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int DM_ACK_CYC = (DM_ACK_NS * (CLK_HZ / 1_000_000)) / 1000;

  typedef struct packed {
    logic cs_b;
    logic ds;
    logic rw;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic drive_pin;
  } tsiha_pins_t;

  localparam tsiha_pins_t PINS_RESET = '{cs_b: 1'b1, ds: 1'b0, rw: 1'b0,
                                         addr: 6'h00, data: 8'h00,
                                         drive_pin: 1'b0};

  typedef struct packed {
    logic valid;
    logic [STRM_W-1:0] stream;
    logic [CHAN_W-1:0] chan;
  } tsiha_slot_req_t;

  typedef struct packed {
    logic valid;
    logic [IDX_W-1:0] idx;
    logic [DATA_W-1:0] data;
  } tsiha_dm_wr_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK = 2'b10
  } tsiha_state_t;

endpackage

// >>> hdl/tsiha_top.sv
// Purpose: Host access decode and per-slot output control of the switch
// Assumes: Host pins are asynchronous; slot and data-memory ports are on
//   the core clock
// Notes: Host reads and writes finish well inside the acknowledge limits
// Function
// - A5,A1,A0 low selects switch_control register
// - A5 high: low five bits index channel
// - Stream field picks memory stream subsection
// - Memory field: 01 data, 10 low, 11 high
// - Split mode: reads data memory, writes low
// - Force bit acts as source and enable set
// - Source bit high outputs low byte each frame
// - Source bit low: low byte addresses data
// - Output drive low holds all slots released
// - Drive high: enable bit gates each slot
// - Low byte bits 6-5 stream, 4-0 channel
// - Acknowledge within 800 ns or 1220 ns
`timescale 1ns/1ps
module tsiha_top
  import tsiha_pkg::*;
(
  input wire logic clk_in,                      // 40 MHz core clock
  input wire logic rst_b_in,                    // async reset, active low
  input wire logic chip_sel_b_in,               // host chip select, low
  input wire logic data_strobe_in,              // host data strobe, high
  input wire logic rw_in,                       // high read, low write
  input wire logic [ADDR_W-1:0] addr_in,        // host address A5..A0
  input wire logic [DATA_W-1:0] data_in,        // host data bus, in
  output logic [DATA_W-1:0] data_out,           // host data bus, out
  output logic data_oe_out,                     // data bus driven
  output logic access_ack_strobe_b_out,         // acknowledge, low
  input wire logic master_output_drive_in,      // master drive pin
  input wire tsiha_slot_req_t slot_req_in,      // next slot to prepare
  input wire tsiha_dm_wr_t dm_wr_in,            // received byte store
  output logic [DATA_W-1:0] slot_data_out,      // prepared slot byte
  output logic slot_drive_out                   // slot driver enable
);

  localparam int ACK_LIM = CM_ACK_CYC;

  // Pin synchronisers
  tsiha_pins_t pins_raw;
  tsiha_pins_t sync1_q;
  tsiha_pins_t sync2_q;

  assign pins_raw = '{cs_b: chip_sel_b_in, ds: data_strobe_in, rw: rw_in,
                      addr: addr_in, data: data_in,
                      drive_pin: master_output_drive_in};

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_q <= PINS_RESET;
      sync2_q <= PINS_RESET;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  // Host decode
  tsiha_state_t state_q;
  tsiha_state_t state_d;
  logic [7:0] ctrl_q;
  logic [DATA_W-1:0] rdata_q;
  logic rd_act_q;

  wire req_s = !sync2_q.cs_b && sync2_q.ds;
  wire acc_go = (state_q == ST_IDLE) && req_s;
  wire host_rd = sync2_q.rw;
  wire is_chan = sync2_q.addr[ADDR_CHAN_BIT];
  wire is_ctrl = !is_chan && (sync2_q.addr[1:0] == CTRL_LOW_ADDR);
  wire split_on = ctrl_q[CTRL_SPLIT_BIT];
  wire force_on = ctrl_q[CTRL_FORCE_BIT];
  wire [1:0] mem_sel = ctrl_q[CTRL_MEM_HI:CTRL_MEM_LO];
  wire [STRM_W-1:0] strm_sel = ctrl_q[CTRL_STRM_HI:CTRL_STRM_LO];
  // Split routing is fixed per direction, ignoring the memory field
  wire [1:0] eff_mem = !split_on ? mem_sel :
                       (host_rd ? MEM_DATA : MEM_CONN_LOW);
  wire [IDX_W-1:0] host_idx = {strm_sel, sync2_q.addr[CHAN_W-1:0]};
  wire chan_wr = acc_go && is_chan && !host_rd;
  wire low_we = chan_wr && (eff_mem == MEM_CONN_LOW);
  wire high_we = chan_wr && (eff_mem == MEM_CONN_HIGH);
  wire ctrl_we = acc_go && is_ctrl && !host_rd;

  logic [DATA_W-1:0] dm_host;
  logic [DATA_W-1:0] low_host;
  logic [DATA_W-1:0] high_host;
  logic [DATA_W-1:0] dm_slot;
  logic [DATA_W-1:0] low_slot;
  logic [DATA_W-1:0] high_slot;

  // Code 00 and unmapped addresses read as zero
  wire [DATA_W-1:0] chan_rd =
    (eff_mem == MEM_DATA) ? dm_host :
    (eff_mem == MEM_CONN_LOW) ? low_host :
    (eff_mem == MEM_CONN_HIGH) ? high_host : 8'h00;
  wire [DATA_W-1:0] rd_mux = is_chan ? chan_rd :
                             (is_ctrl ? (ctrl_q & CTRL_RW_MASK) :
                             8'h00);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (req_s) begin
          state_d = ST_ACK;
        end
      end
      ST_ACK: begin
        if (!req_s) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_q <= CTRL_RESET;
    end else if (ctrl_we) begin
      ctrl_q <= sync2_q.data & CTRL_RW_MASK;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_q <= 8'h00;
      rd_act_q <= 1'b0;
    end else if (acc_go) begin
      rdata_q <= host_rd ? rd_mux : 8'h00;
      rd_act_q <= host_rd;
    end
  end

  assign data_out = rdata_q;
  assign data_oe_out = (state_q == ST_ACK) && rd_act_q;
  assign access_ack_strobe_b_out = (state_q != ST_ACK);

  // Slot preparation
  wire [IDX_W-1:0] slot_idx = {slot_req_in.stream, slot_req_in.chan};
  wire [IDX_W-1:0] src_idx = low_slot[LOW_ADDR_HI:LOW_ADDR_LO];
  wire src_cpu = force_on || high_slot[HIGH_SRC_BIT];
  wire src_oe = force_on || high_slot[HIGH_OE_BIT];
  logic [DATA_W-1:0] slot_data_q;
  logic slot_oe_q;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      slot_data_q <= 8'h00;
      slot_oe_q <= 1'b0;
    end else if (slot_req_in.valid) begin
      slot_data_q <= src_cpu ? low_slot : dm_slot;
      slot_oe_q <= src_oe;
    end
  end

  assign slot_data_out = slot_data_q;
  // Gated after the register so a falling drive pin releases once through the two sync flops, with no new request
  assign slot_drive_out = slot_oe_q && sync2_q.drive_pin;

  // Data memory has no host write port at all
  tsiha_mem u_dm (
    .clk_in(clk_in),
    .wr_en_in(dm_wr_in.valid),
    .wr_idx_in(dm_wr_in.idx),
    .wr_data_in(dm_wr_in.data),
    .rd_a_idx_in(host_idx),
    .rd_a_data_out(dm_host),
    .rd_b_idx_in(src_idx),
    .rd_b_data_out(dm_slot)
  );

  tsiha_mem u_low_mem (
    .clk_in(clk_in),
    .wr_en_in(low_we),
    .wr_idx_in(host_idx),
    .wr_data_in(sync2_q.data),
    .rd_a_idx_in(host_idx),
    .rd_a_data_out(low_host),
    .rd_b_idx_in(slot_idx),
    .rd_b_data_out(low_slot)
  );

  tsiha_mem u_high_mem (
    .clk_in(clk_in),
    .wr_en_in(high_we),
    .wr_idx_in(host_idx),
    .wr_data_in(sync2_q.data),
    .rd_a_idx_in(host_idx),
    .rd_a_data_out(high_host),
    .rd_b_idx_in(slot_idx),
    .rd_b_data_out(high_slot)
  );

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  ctrl_write_a: assert property (
    ctrl_we |=> ctrl_q == ($past(sync2_q.data) & CTRL_RW_MASK))
    else $error("control write not stored");

  ctrl_read_a: assert property (
    acc_go && host_rd && is_ctrl |=> rdata_q == $past(ctrl_q))
    else $error("control read data wrong");

  chan_read_a: assert property (
    acc_go && host_rd && is_chan && eff_mem == MEM_CONN_LOW
    |=> rdata_q == $past(low_host) ##1 !data_oe_out || rd_act_q)
    else $error("channel read data wrong");

  stream_idx_a: assert property (
    low_we |-> host_idx[IDX_W-1:CHAN_W] == ctrl_q[CTRL_STRM_HI:CTRL_STRM_LO])
    else $error("stream field not used in index");

  dm_read_a: assert property (
    acc_go && host_rd && is_chan && !split_on && mem_sel == MEM_DATA
    |=> rdata_q == $past(dm_host))
    else $error("data memory read wrong");

  high_write_a: assert property (
    chan_wr && !split_on && mem_sel == MEM_CONN_HIGH |-> high_we && !low_we)
    else $error("high memory write misrouted");

  code_zero_a: assert property (
    acc_go && is_chan && eff_mem == MEM_NONE && host_rd
    |=> rdata_q == 8'h00)
    else $error("code 00 read not zero");

  split_route_a: assert property (
    split_on && chan_wr |-> low_we && !high_we)
    else $error("split write not routed to low memory");

  split_read_a: assert property (
    acc_go && host_rd && is_chan && split_on
    |=> rdata_q == $past(dm_host))
    else $error("split read not from data memory");

  force_mode_a: assert property (
    slot_req_in.valid && force_on
    |=> slot_data_q == $past(low_slot) && slot_oe_q)
    else $error("forced processor mode not applied");

  proc_mode_a: assert property (
    slot_req_in.valid && !force_on && high_slot[HIGH_SRC_BIT]
    |=> slot_data_q == $past(low_slot))
    else $error("processor mode byte wrong");

  conn_mode_a: assert property (
    slot_req_in.valid && !force_on && !high_slot[HIGH_SRC_BIT]
    |=> slot_data_q == $past(dm_slot) && $past(src_idx) ==
        $past(low_slot[6:0]))
    else $error("connection mode byte wrong");

  drive_hold_a: assert property (
    !sync2_q.drive_pin |-> !slot_drive_out)
    else $error("slot driven while drive pin low");

  oe_gate_a: assert property (
    slot_req_in.valid && !force_on && !high_slot[HIGH_OE_BIT]
    |=> !slot_drive_out)
    else $error("disabled channel driven");

  ack_bound_a: assert property (
    $rose(req_s) |-> ##[1:ACK_LIM] !access_ack_strobe_b_out)
    else $error("acknowledge too late");

  ack_follow_a: assert property (
    acc_go |=> !access_ack_strobe_b_out)
    else $error("acknowledge not raised");

  read_drive_a: assert property (
    acc_go && host_rd |=> data_oe_out)
    else $error("read data not driven");

  unmapped_a: assert property (
    acc_go && !is_chan && !is_ctrl
    |=> rdata_q == 8'h00 && ctrl_q == $past(ctrl_q))
    else $error("unmapped access had effect");

  dm_ignore_a: assert property (
    chan_wr && eff_mem == MEM_DATA |-> !low_we && !high_we)
    else $error("data memory write reached a memory");

  cover_ctrl_c: cover property (ctrl_we ##[1:8] !access_ack_strobe_b_out);
  cover_split_c: cover property (acc_go && split_on && host_rd);
  cover_proc_c: cover property (slot_req_in.valid && high_slot[HIGH_SRC_BIT]);
  cover_force_c: cover property (slot_req_in.valid && force_on
                                 ##1 slot_drive_out);

endmodule
